/* File: shared/gpio_dac_map.vh */
// constants for the pin and converter serial command block
`ifndef GPIO_DAC_MAP_VH
`define GPIO_DAC_MAP_VH

// command bytes
`define CMD_PIN_CFG 8'h03
`define CMD_PIN_WR 8'h02
`define CMD_PIN_RD 8'h01
`define CMD_DAC_SEL 4'h1

// bit counter marks (index of the last bit of a field, and the count where the counter holds)
`define BIT_CMD_LAST 5'h07
`define BIT_BYTE2_LAST 5'h0F
`define BIT_WORD_LAST 5'h17
`define BIT_CNT_MAX 5'h1F

// converter control codes
`define DAC_RESET 4'h1
`define DAC_LOAD0 4'h2
`define DAC_LOAD1 4'h3
`define DAC_LOAD2 4'h4
`define DAC_LOAD3 4'h5
`define DAC_THRU_A 4'hA
`define DAC_THRU_C 4'hC
`define DAC_IN_ALL 4'hD
`define DAC_SW_LOAD 4'hE
`define DAC_POWER 4'hF
`define LOAD_BASE 2'h2

// power field values (data bits 3..1)
`define PWR_UP 3'h1
`define PWR_HIZ 3'h2
`define PWR_GND1K 3'h4
`define PWR_GND100K 3'h0
`define PWR_REF100K 3'h7

// buffer state encodings on the mode outputs
`define BUF_ACTIVE 3'h0
`define BUF_HIZ 3'h1
`define BUF_GND1K 3'h2
`define BUF_GND100K 3'h3
`define BUF_REF100K 3'h4
`define BUF_RESET 3'h3

// field positions and widths
`define SEL_LSB 4
`define CODE_W 12
`define MODE_W 3

// reset and fill values
`define CODE_ZERO 12'h000
`define CODE_ONES 12'hFFF
`define PIN_CFG_RESET 4'h0
`define PIN_WR_RESET 4'hF
`define LEAD_ZEROS 4'h0
`define SYNC_LINK_RESET 4'h9
`define PIN_LEVEL_RESET 4'h0

`endif

/* File: design/pin_sync.v */
// two-stage synchroniser for asynchronous inputs
`timescale 1ns/100ps
module pin_sync #(
  parameter W = 1,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // raw and synchronised levels
  input wire [W-1:0] rawIn,
  output reg [W-1:0] syncOut
);

  reg [W-1:0] stage1; // read only by the second stage

  // two flops, reset to the idle level of each line
  always @(posedge clk) begin
    if (!resetn) begin
      stage1 <= RST;
      syncOut <= RST;
    end else begin
      stage1 <= rawIn;
      syncOut <= stage1;
    end
  end

endmodule // pin_sync

/* File: design/pin_cell.v */
// one general-purpose pin: mode decode to drive value and enable
`timescale 1ns/100ps
module pin_cell (
  // clock and reset
  input wire clk,
  input wire resetn,
  // committed register bits for this pin
  input wire cfgBit,
  input wire wrBit,
  // pad drive
  output reg pinOut,
  output reg pinOe
);

  // 11 high, 10 low, 01 input, 00 open-drain pulldown
  always @(posedge clk) begin
    if (!resetn) begin
      pinOut <= 1'b0; // input after reset
      pinOe <= 1'b0;
    end else begin
      pinOut <= cfgBit & wrBit;
      pinOe <= cfgBit | ~wrBit;
    end
  end

endmodule // pin_cell

/* File: design/gpio_dac_serial.v */
// serial command interpreter for pins and the quad output converter
//
// Functional notes
// - pin configure: 03h then data, zeros out; a result ready at frame start goes out instead
// - pin write: 02h then data, zeros out; a result ready at frame start goes out instead
// - pin decode: high, low, input, open-drain low
// - pin read: 01h, then four zeros, pins
// - 16-bit word, four control; unlisted codes nop
// - code 1 top bit 0 clears registers
// - code 1 top bit 1 presets registers
// - codes 2..5 load one input register
// - codes A, C write through all channels
// - code D loads all input registers only
// - code E copies selected inputs to outputs
// - power code 001 powers selected buffers up
// - power code 010 leaves selected high impedance
// - power codes 100, 000 tie to ground
// - power code 111 ties to reference pin
// - result: four zeros then twelve bits
// - output data changes on clock falling edge
// - bipolar results in two's complement form
// - bits taken on falling edge; short discarded
// - pin registers update on chip select rise
// - all pins are inputs after reset
`timescale 1ns/100ps
`include "gpio_dac_map.vh"
module gpio_dac_serial (
  // clock and reset
  input wire ref_clk,
  input wire resetn,
  // serial link pins
  input wire csN,
  input wire sclk,
  input wire din,
  output reg dout,
  output reg doutOe,
  // hardware load strobe
  input wire loadOutputsStrobeN,
  // general-purpose pins, bit 3 port_c_pin_1 .. bit 0 port_a_pin_0
  input wire [3:0] pinIn,
  output wire [3:0] pinOut,
  output wire [3:0] pinOe,
  // converter output registers and buffer states
  output reg [47:0] dacCodes,
  output reg [11:0] dacBufMode,
  // conversion result from the input converter
  input wire [11:0] resultCode,
  input wire resultBipolar,
  input wire resultReady,
  output reg resultTaken
);

  // phases of a transaction
  localparam PH_CMD = 3'h0;
  localparam PH_CFG = 3'h1;
  localparam PH_WR = 3'h2;
  localparam PH_RD = 3'h3;
  localparam PH_DAC = 3'h4;
  localparam PH_SKIP = 3'h5;

  // synchronised link lines
  wire [3:0] linkSync;
  wire csS = linkSync[3];
  wire sclkS = linkSync[2];
  wire dinS = linkSync[1];
  wire ldacS = linkSync[0];
  wire [3:0] pinState; // synchronised pin levels

  // edge history
  reg csPrev;
  reg sclkPrev;
  reg ldacPrev;

  // serial state
  reg [2:0] phase;
  reg [4:0] bitCnt; // bits taken since chip select fell
  reg [15:0] rxShift; // received bits, newest at bit 0
  reg [15:0] txShift; // bit 15 is on dout now
  reg resultLoaded; // a result is being shifted out

  // pin registers and the pending write
  reg [3:0] pinCfg;
  reg [3:0] pinWr;
  reg [3:0] pendData;
  reg pendIsCfg;
  reg pendValid;

  // converter input registers
  reg [47:0] inCodes;

  integer ch;

  // edges seen on the synchronised lines
  wire csFall = csPrev & ~csS;
  wire csRise = ~csPrev & csS;
  wire sclkFall = sclkPrev & ~sclkS;
  wire ldacFall = ldacPrev & ~ldacS;

  // byte and word including the bit taken on this edge
  wire [7:0] rxByte = {rxShift[6:0], dinS};
  wire [15:0] rxWord = {rxShift[14:0], dinS};
  wire [3:0] ctl = rxWord[15:12];
  wire [11:0] dData = rxWord[11:0];
  wire [1:0] loadIdx = ctl[1:0] - `LOAD_BASE;

  // result framing: raw converter code is offset binary, so the
  // sign form only needs the top bit turned over
  wire [11:0] codedResult = resultBipolar ?
    {~resultCode[11], resultCode[10:0]} : resultCode;
  wire [15:0] fmtResult = {`LEAD_ZEROS, codedResult};

  // power field decode
  reg pwrValid;
  reg [2:0] pwrMode;

  // map the power field to a buffer state
  always @* begin
    pwrValid = 1'b1;
    pwrMode = `BUF_ACTIVE;
    case (dData[3:1])
      `PWR_UP: pwrMode = `BUF_ACTIVE;
      `PWR_HIZ: pwrMode = `BUF_HIZ;
      `PWR_GND1K: pwrMode = `BUF_GND1K;
      `PWR_GND100K: pwrMode = `BUF_GND100K;
      `PWR_REF100K: pwrMode = `BUF_REF100K;
      default: pwrValid = 1'b0;
    endcase
  end

  // link lines, idle chip select and strobe high
  pin_sync #(
    .W(4),
    .RST(`SYNC_LINK_RESET)
  ) linkSyncInst (
    .clk(ref_clk),
    .resetn(resetn),
    .rawIn({csN, sclk, din, loadOutputsStrobeN}),
    .syncOut(linkSync)
  );

  // pin levels for read-back
  pin_sync #(
    .W(4),
    .RST(`PIN_LEVEL_RESET)
  ) pinSyncInst (
    .clk(ref_clk),
    .resetn(resetn),
    .rawIn(pinIn),
    .syncOut(pinState)
  );

  // one pad driver per pin
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : pinGen
      pin_cell cellInst (
        .clk(ref_clk),
        .resetn(resetn),
        .cfgBit(pinCfg[gi]),
        .wrBit(pinWr[gi]),
        .pinOut(pinOut[gi]),
        .pinOe(pinOe[gi])
      );
    end
  endgenerate

  // edge history registers
  always @(posedge ref_clk) begin
    if (!resetn) begin
      csPrev <= 1'b1;
      sclkPrev <= 1'b0;
      ldacPrev <= 1'b1;
    end else begin
      csPrev <= csS;
      sclkPrev <= sclkS;
      ldacPrev <= ldacS;
    end
  end

  // main interpreter: framing, pin registers, converter registers
  always @(posedge ref_clk) begin
    if (!resetn) begin
      phase <= PH_SKIP;
      bitCnt <= 5'h00;
      rxShift <= 16'h0000;
      txShift <= 16'h0000;
      resultLoaded <= 1'b0;
      resultTaken <= 1'b0;
      dout <= 1'b0;
      doutOe <= 1'b0;
      pinCfg <= `PIN_CFG_RESET;
      pinWr <= `PIN_WR_RESET;
      pendData <= 4'h0;
      pendIsCfg <= 1'b0;
      pendValid <= 1'b0;
      inCodes <= {4{`CODE_ZERO}};
      dacCodes <= {4{`CODE_ZERO}};
      dacBufMode <= {4{`BUF_RESET}};
    end else begin
      resultTaken <= 1'b0;
      // hardware strobe loads every output; a command in the
      // same cycle is applied after it and wins per channel
      if (ldacFall)
        dacCodes <= inCodes;
      if (csFall) begin
        // new frame; a result is offered only when one is ready
        phase <= PH_CMD;
        bitCnt <= 5'h00;
        pendValid <= 1'b0;
        doutOe <= 1'b1;
        resultLoaded <= resultReady;
        if (resultReady) begin
          txShift <= fmtResult;
          dout <= fmtResult[15];
        end else begin
          txShift <= 16'h0000;
          dout <= 1'b0;
        end
      end else if (csRise) begin
        // end of frame; short frames never set the pending flag
        doutOe <= 1'b0;
        dout <= 1'b0;
        phase <= PH_SKIP;
        resultLoaded <= 1'b0;
        pendValid <= 1'b0;
        if (pendValid) begin
          if (pendIsCfg)
            pinCfg <= pendData;
          else
            pinWr <= pendData;
        end
      end else if (!csS && sclkFall) begin
        // take a bit and move dout on the same falling edge
        rxShift <= rxWord;
        if (bitCnt != `BIT_CNT_MAX)
          bitCnt <= bitCnt + 5'h01;
        txShift <= {txShift[14:0], 1'b0};
        dout <= txShift[14];
        if (resultLoaded && bitCnt == `BIT_BYTE2_LAST) begin
          resultTaken <= 1'b1;
          resultLoaded <= 1'b0;
        end
        case (phase)
          PH_CMD: begin
            if (bitCnt == `BIT_CMD_LAST) begin
              if (rxByte == `CMD_PIN_CFG)
                phase <= PH_CFG;
              else if (rxByte == `CMD_PIN_WR)
                phase <= PH_WR;
              else if (rxByte == `CMD_PIN_RD) begin
                phase <= PH_RD;
                // read overrides any result: zeros then pins
                txShift <= {`LEAD_ZEROS, pinState, 8'h00};
                dout <= 1'b0;
                resultLoaded <= 1'b0;
              end else if (rxByte[7:4] == `CMD_DAC_SEL)
                phase <= PH_DAC;
              else
                phase <= PH_SKIP;
            end
          end
          PH_CFG, PH_WR: begin
            // upper nibble kept, lower nibble ignored
            if (bitCnt == `BIT_BYTE2_LAST) begin
              pendData <= rxByte[7:4];
              pendIsCfg <= (phase == PH_CFG);
              pendValid <= 1'b1;
              phase <= PH_SKIP;
            end
          end
          PH_RD: begin
            if (bitCnt == `BIT_BYTE2_LAST)
              phase <= PH_SKIP;
          end
          PH_DAC: begin
            // the word acts only once all sixteen bits arrived
            if (bitCnt == `BIT_WORD_LAST) begin
              phase <= PH_SKIP;
              case (ctl)
                `DAC_RESET: begin
                  if (dData[11]) begin
                    inCodes <= {4{`CODE_ONES}};
                    dacCodes <= {4{`CODE_ONES}};
                  end else begin
                    inCodes <= {4{`CODE_ZERO}};
                    dacCodes <= {4{`CODE_ZERO}};
                  end
                end
                `DAC_LOAD0, `DAC_LOAD1, `DAC_LOAD2, `DAC_LOAD3:
                  inCodes[loadIdx * `CODE_W +: `CODE_W] <= dData;
                `DAC_THRU_A, `DAC_THRU_C: begin
                  inCodes <= {4{dData}};
                  dacCodes <= {4{dData}};
                end
                `DAC_IN_ALL:
                  inCodes <= {4{dData}};
                `DAC_SW_LOAD: begin
                  for (ch = 0; ch < 4; ch = ch + 1)
                    if (dData[`SEL_LSB + ch])
                      dacCodes[ch * `CODE_W +: `CODE_W] <=
                        inCodes[ch * `CODE_W +: `CODE_W];
                end
                `DAC_POWER: begin
                  for (ch = 0; ch < 4; ch = ch + 1)
                    if (pwrValid && dData[`SEL_LSB + ch])
                      dacBufMode[ch * `MODE_W +: `MODE_W] <=
                        pwrMode;
                end
                default: ; // no operation
              endcase
            end
          end
          default: ; // bits past the command are ignored
        endcase
      end
    end
  end

endmodule // gpio_dac_serial

/* File: sim/gpio_dac_serial_properties.sv */
// port assertions for the pin and converter command block
`timescale 1ns/100ps
module gpio_dac_serial_properties (
  // clock and reset
  input wire ref_clk,
  input wire resetn,
  // link and strobe
  input wire csN,
  input wire sclk,
  input wire dout,
  input wire doutOe,
  input wire loadOutputsStrobeN,
  // pins, converter, result
  input wire [3:0] pinOut,
  input wire [3:0] pinOe,
  input wire [47:0] dacCodes,
  input wire [11:0] dacBufMode,
  input wire resultTaken
);
  // one domain: one clock and reset for all
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  property p_rst;
    $rose(resetn) |-> pinOe == 4'h0 && dacCodes == 48'h0 &&
      dacBufMode == 12'h6DB;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_oe_on;
    $fell(csN) |-> ##[2:6] doutOe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("no drive");
  property p_oe_off;
    csN[*6] |-> !doutOe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("drive idle");
  // no sclk fall for six cycles, so data must hold
  property p_hold;
    (sclk && doutOe && !csN)[*6] |-> $stable(dout);
  endproperty
  a_hold: assert property (p_hold) else $error("dout moved");
  // pins commit only after the frame closes
  property p_pins;
    (!csN)[*8] |-> $stable(pinOe) && $stable(pinOut);
  endproperty
  a_pins: assert property (p_pins) else $error("pin early");
  property p_codes;
    (sclk && loadOutputsStrobeN)[*8] |-> $stable(dacCodes);
  endproperty
  a_codes: assert property (p_codes) else $error("codes moved");
  property p_modes;
    csN[*8] |-> $stable(dacBufMode) && !resultTaken;
  endproperty
  a_modes: assert property (p_modes) else $error("mode moved");
  property p_taken;
    resultTaken |-> doutOe ##1 !resultTaken;
  endproperty
  a_taken: assert property (p_taken) else $error("taken pulse");
  property p_drive;
    (pinOut & ~pinOe) == 4'h0;
  endproperty
  a_drive: assert property (p_drive) else $error("pin drive");
endmodule // gpio_dac_serial_properties

bind gpio_dac_serial gpio_dac_serial_properties chk_u (
  .ref_clk(ref_clk), .resetn(resetn), .csN(csN), .sclk(sclk),
  .dout(dout), .doutOe(doutOe), .loadOutputsStrobeN(loadOutputsStrobeN),
  .pinOut(pinOut), .pinOe(pinOe), .dacCodes(dacCodes),
  .dacBufMode(dacBufMode), .resultTaken(resultTaken));

/* File: sim/serial_host_model.sv */
// serial host model: frames on the link, msb first
`timescale 1ns/100ps
module serial_host_model (
  // frame alignment only
  input wire ref_clk,
  // serial link
  output logic csN,
  output logic sclk,
  output logic din,
  input wire dout
);
  // idle: deselected, clock parked high
  initial begin
    csN = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  // send first n bits of tx; rx gets the stream seen before each fall
  task automatic xfer(input logic [23:0] tx, input int n,
    output logic [23:0] rx);
    rx = 24'h0;
    @(negedge ref_clk);
    #0.3 csN = 1'b0; // off-edge start keeps phase unrelated
    #62.5;
    for (int i = 0; i < n; i++) begin
      din = tx[23 - i];
      #62.5 rx[23 - i] = dout;
      sclk = 1'b0;
      #62.5 sclk = 1'b1;
    end
    #62.5 csN = 1'b1;
    din = ~din; // released line must not look held
    #62.5;
  endtask
endmodule // serial_host_model

/* File: sim/gpio_dac_serial_tb_top.sv */
// self-checking bench for the pin and converter command block
`timescale 1ns/100ps
`define CHK(n, e, a) begin checksDone++; if ((a) !== (e)) begin \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, a); errCount++; end end
module gpio_dac_serial_tb_top;
  logic ref_clk, resetn, strobeN, rdy, bip;
  logic [3:0] ext, cfg, wr; // ext: far pad levels
  logic [11:0] code, inR[4], outR[4]; // expected registers
  logic [2:0] mode[4];
  logic [23:0] rx, w;
  logic [31:0] x, rs = 32'h3; // xorshift state
  int errCount, checksDone, taken;
  wire csN, sclk, din, dout, doutOe, resultTaken;
  // a released line shows the inverse, so a stale bit cannot pass
  wire doutPad = doutOe ? dout : ~dout;
  wire [3:0] pinOut, pinOe;
  wire [3:0] pinIn = (pinOe & pinOut) | (~pinOe & ext); // resolved pads
  wire [47:0] dacCodes;
  wire [11:0] dacBufMode;
  gpio_dac_serial dut_u (.ref_clk(ref_clk), .resetn(resetn), .csN(csN),
    .sclk(sclk), .din(din), .dout(dout), .doutOe(doutOe),
    .loadOutputsStrobeN(strobeN), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .dacCodes(dacCodes), .dacBufMode(dacBufMode),
    .resultCode(code), .resultBipolar(bip), .resultReady(rdy),
    .resultTaken(resultTaken));
  serial_host_model host_u (.ref_clk(ref_clk), .csN(csN), .sclk(sclk),
    .din(din), .dout(doutPad));
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // power field to buffer state; unlisted fields keep the state
  function automatic logic [2:0] pwr(logic [2:0] f, logic [2:0] m);
    case (f)
      3'h1: return 3'h0;
      3'h2: return 3'h1;
      3'h4: return 3'h2;
      3'h0: return 3'h3;
      3'h7: return 3'h4;
      default: return m;
    endcase
  endfunction
  // reference model of one converter word
  function automatic void apply(logic [15:0] v);
    for (int k = 0; k < 4; k++) begin
      if (v[15:12] == 4'h1)
        inR[k] = {12{v[11]}};
      if (v[15:12] == 4'h1)
        outR[k] = inR[k];
      if (v[15:12] inside {4'hA, 4'hC, 4'hD} || v[15:12] == k + 2)
        inR[k] = v[11:0];
      if (v[15:12] inside {4'hA, 4'hC} || (v[15:12] == 4'hE && v[4 + k]))
        outR[k] = inR[k];
      if (v[15:12] == 4'hF && v[4 + k])
        mode[k] = pwr(v[3:1], mode[k]);
    end
  endfunction
  task automatic chkDac(string n);
    repeat (8) @(negedge ref_clk);
    for (int k = 0; k < 4; k++) begin
      `CHK(n, outR[k], dacCodes[12 * k +: 12])
      `CHK(n, mode[k], dacBufMode[3 * k +: 3])
    end
  endtask
  task automatic endSim();
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (resultTaken === 1'b1) taken++;
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (90000) @(posedge ref_clk);
    errCount++;
    endSim();
  end
  initial begin
    resetn = 1'b0;
    strobeN = 1'b1;
    rdy = 1'b0;
    bip = 1'b0;
    code = 12'h000;
    ext = 4'h0;
    for (int k = 0; k < 4; k++) begin
      inR[k] = 12'h000;
      outR[k] = 12'h000;
      mode[k] = 3'h3;
    end
    repeat (8) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    `CHK("pinOe", 4'h0, pinOe)
    // first pass sets all four mode pairs at once
    for (int i = 0; i < 6; i++) begin
      @(negedge ref_clk);
      x = rnd();
      cfg = (i == 0) ? 4'h5 : x[3:0];
      wr = (i == 0) ? 4'h3 : x[7:4];
      ext = x[11:8];
      host_u.xfer({8'h02, wr, 12'hA00}, 16, rx);
      `CHK("wr out", 16'h0, rx[23:8])
      host_u.xfer({8'h03, cfg, 12'h500}, 16, rx);
      `CHK("cfg out", 16'h0, rx[23:8])
      repeat (8) @(negedge ref_clk);
      `CHK("pinOe", cfg | ~wr, pinOe)
      `CHK("pinOut", cfg & wr, pinOut)
      host_u.xfer(24'h010000, 16, rx);
      `CHK("read", {12'h0, (cfg & wr) | (~cfg & wr & ext)}, rx[23:8])
    end
    $display("pin test done");
    for (int i = 0; i < 48; i++) begin
      x = rnd();
      w = {4'h1, x[31:28], (i < 16) ? i[3:0] : x[15:12], x[11:0]};
      if (i >= 16 && i < 32)
        w[15:12] = 4'hF;
      if (i >= 16 && i < 32)
        w[3:1] = i[2:0];
      host_u.xfer(w, 24, rx);
      apply(w[15:0]);
      chkDac("word");
      if (x[16]) begin
        @(negedge ref_clk) strobeN = 1'b0;
        repeat (3) @(negedge ref_clk);
        strobeN = 1'b1;
        for (int k = 0; k < 4; k++) outR[k] = inR[k];
        chkDac("strobe");
      end
    end
    // a frame cut short must not act
    host_u.xfer({8'h10, 16'hA5A5}, 20, rx);
    chkDac("short");
    $display("converter test done");
    // the last frame is a pin read while a result waits: read wins
    for (int i = 0; i < 5; i++) begin
      @(negedge ref_clk);
      x = rnd();
      code = x[11:0];
      bip = x[12];
      rdy = 1'b1;
      taken = 0;
      host_u.xfer((i == 4) ? 24'h010000 : 24'h0, 16, rx);
      @(negedge ref_clk) rdy = 1'b0;
      if (i == 4) begin
        `CHK("read over", (cfg & wr) | (~cfg & wr & ext), rx[11:8])
        `CHK("read lead", 4'h0, rx[15:12])
        `CHK("read taken", 0, taken)
      end else begin
        `CHK("result", {4'h0, code ^ {bip, 11'h0}}, rx[23:8])
        `CHK("taken", 1, taken)
      end
    end
    $display("result test done");
    endSim();
  end
endmodule // gpio_dac_serial_tb_top
